// *** include/sdl_pkg.sv ***
// package for the serial converter load logic
package sdl_pkg;
  localparam int WORD_W = 12;
  localparam int FIFO_DEPTH = 4;
  localparam int CODE_SPAN = 4096;
  localparam logic [11:0] CODE_RESET = 12'h000;
  // strobe synchroniser resets to the idle high level, so no false load follows reset
  localparam logic [2:0] SYNC_RESET = 3'h7;
  // one converter word on its way to the ladder side
  typedef struct packed {
    logic [11:0] code;
  } sdl_word_s;
endpackage : sdl_pkg

// *** core/sdl_fifo.sv ***
// small flip-flop fifo with valid and ready on both sides
`timescale 1ns/1ps
module sdl_fifo #(
  parameter int WIDTH = 12,
  parameter int DEPTH = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // fill side
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // drain side
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0] wr_ptr_reg;
  logic [AW-1:0] rd_ptr_reg;
  logic [AW:0] count_reg;
  wire push = in_valid && in_ready;
  wire pop = out_valid && out_ready;
  // honest full and empty from the occupancy count
  assign in_ready = (count_reg != (AW + 1)'(DEPTH));
  assign out_valid = (count_reg != '0);
  assign out_data = mem_reg[rd_ptr_reg];

  // storage write
  always_ff @(posedge clk) begin
    if (push) begin
      mem_reg[wr_ptr_reg] <= in_data;
    end
  end

  // pointers and count
  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW + 1)'(push) - (AW + 1)'(pop);
    end
  end
endmodule : sdl_fifo

// *** core/sdl_load_logic.sv ***
// serial shift register, level-sensitive load and converter code output
//
// Behaviour
// - On a link clock rise with the load strobe high the shift register advances one bit and the converter register holds.
// - While the load strobe is low nothing shifts and the converter register follows the shift register, keeping all 12 bits when the strobe rises.
// - The load is level-sensitive, so a low strobe passes the shift register contents through the fifo to the code, which moves only while CODE_READY is high.
// - Words arrive most significant bit first, so the last bit shifted in is the least significant.
// - The code is an unsigned straight-binary value from 0 to 4095, output proportional to minus code over 4096.
// - Bits beyond twelve before a load push the earliest ones out and only the last twelve remain.
`timescale 1ns/1ps
module sdl_load_logic #(
  parameter int WORD_W = sdl_pkg::WORD_W,
  parameter int FIFO_DEPTH = sdl_pkg::FIFO_DEPTH
) (
  // core clock and reset
  input wire logic CORE_CLK,
  input wire logic RST,
  // serial link from the host
  input wire logic LINK_CLK,
  input wire logic SERIAL_DATA_IN,
  input wire logic LOAD_STROBE_N,
  // converter code towards the ladder
  output logic [WORD_W-1:0] DAC_CODE,
  output logic DAC_CODE_VALID,
  output logic LOAD_TRANSPARENT,
  // back-pressure from the ladder side
  input wire logic CODE_READY,
  output logic CODE_STROBE
);
  // link domain: shift register on the serial clock
  logic [WORD_W-1:0] shift_reg;
  logic [WORD_W-1:0] shift_next;
  assign shift_next = {shift_reg[WORD_W-2:0], SERIAL_DATA_IN};

  // no reset pin on the link side; contents undefined until a word is loaded
  always_ff @(posedge LINK_CLK) begin
    if (LOAD_STROBE_N) begin
      shift_reg <= shift_next;
    end
  end

  // strobe into core domain: three flops, change counts when last two agree
  logic [2:0] ld_sync_reg;
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ld_sync_reg <= sdl_pkg::SYNC_RESET;
    end else begin
      ld_sync_reg <= {ld_sync_reg[1:0], LOAD_STROBE_N};
    end
  end
  logic ld_low_reg;
  wire ld_agree = (ld_sync_reg[2] == ld_sync_reg[1]);
  wire ld_low_next = ld_agree ? ~ld_sync_reg[1] : ld_low_reg;
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      ld_low_reg <= 1'b0;
    end else begin
      ld_low_reg <= ld_low_next;
    end
  end

  // shift register word crosses as a multi-bit bus; it is stable while the
  // strobe is low because no shifting happens then, so a two-flop sample
  // of each bit settles before the strobe is seen low after three flops
  logic [WORD_W-1:0] word_s1_reg;
  logic [WORD_W-1:0] word_s2_reg;
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      word_s1_reg <= sdl_pkg::CODE_RESET;
      word_s2_reg <= sdl_pkg::CODE_RESET;
    end else begin
      word_s1_reg <= shift_reg;
      word_s2_reg <= word_s1_reg;
    end
  end

  // transparent latch emulated per core cycle while the strobe is low;
  // the register only moves once the fifo takes the word, so a full fifo
  // leaves it differing and the latest word is offered again
  logic fifo_in_ready;
  logic fifo_out_valid;
  sdl_pkg::sdl_word_s push_word;
  sdl_pkg::sdl_word_s fifo_out_word;
  logic [WORD_W-1:0] dac_reg;
  wire dac_load = ld_low_reg && fifo_in_ready;
  wire [WORD_W-1:0] dac_next = dac_load ? word_s2_reg : dac_reg;
  wire code_changed = ld_low_reg && (word_s2_reg != dac_reg);
  assign push_word.code = word_s2_reg;
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      dac_reg <= sdl_pkg::CODE_RESET;
    end else begin
      dac_reg <= dac_next;
    end
  end

  // every new code value goes into the fifo towards the ladder side
  sdl_fifo #(.WIDTH($bits(sdl_pkg::sdl_word_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk(CORE_CLK),
    .rst(RST),
    .in_valid(code_changed),
    .in_ready(fifo_in_ready),
    .in_data(push_word),
    .out_valid(fifo_out_valid),
    .out_ready(CODE_READY),
    .out_data(fifo_out_word)
  );
  // a full fifo refuses the change; dac_reg then holds and keeps differing
  wire take = fifo_out_valid && CODE_READY;

  // registered outputs; code is unsigned straight binary 0..4095
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      DAC_CODE <= sdl_pkg::CODE_RESET;
      DAC_CODE_VALID <= 1'b0;
      LOAD_TRANSPARENT <= 1'b0;
      CODE_STROBE <= 1'b0;
    end else begin
      if (take) begin
        DAC_CODE <= fifo_out_word.code;
        DAC_CODE_VALID <= 1'b1;
      end
      LOAD_TRANSPARENT <= ld_low_reg;
      CODE_STROBE <= take;
    end
  end
endmodule : sdl_load_logic

// *** verif/sdl_load_logic_properties.sv ***
// port checker for the serial load logic
`timescale 1ns/1ps
module sdl_load_logic_properties #(parameter int WORD_W = 12, parameter int FIFO_DEPTH = 4) (
  // clocks, reset, link and code side
  input wire logic CORE_CLK, input wire logic RST, input wire logic LINK_CLK,
  input wire logic SERIAL_DATA_IN, input wire logic LOAD_STROBE_N, input wire logic CODE_READY,
  input wire logic [WORD_W-1:0] DAC_CODE, input wire logic DAC_CODE_VALID,
  input wire logic LOAD_TRANSPARENT, input wire logic CODE_STROBE);
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (RST);
  property p_hold; $changed(DAC_CODE) |-> CODE_STROBE; endproperty
  a_hold: assert property (p_hold) else $error("code moved alone");
  property p_quiet; (LOAD_STROBE_N && CODE_READY) [*8] |-> !CODE_STROBE; endproperty
  a_quiet: assert property (p_quiet) else $error("update while latched");
  property p_open; !LOAD_STROBE_N [*5] |=> LOAD_TRANSPARENT; endproperty
  a_open: assert property (p_open) else $error("not transparent");
  property p_shut; LOAD_STROBE_N [*5] |=> !LOAD_TRANSPARENT; endproperty
  a_shut: assert property (p_shut) else $error("not latched");
  property p_valid; CODE_STROBE |=> DAC_CODE_VALID; endproperty
  a_valid: assert property (p_valid) else $error("code not valid");
  property p_keep; DAC_CODE_VALID |=> DAC_CODE_VALID; endproperty
  a_keep: assert property (p_keep) else $error("valid dropped");
  cover property (LOAD_TRANSPARENT);
  cover property (CODE_STROBE);
  cover property (!CODE_READY && LOAD_TRANSPARENT);
endmodule : sdl_load_logic_properties
bind sdl_load_logic sdl_load_logic_properties #(.WORD_W(WORD_W), .FIFO_DEPTH(FIFO_DEPTH))
  sdl_load_logic_properties_i (.CORE_CLK, .RST, .LINK_CLK, .SERIAL_DATA_IN, .LOAD_STROBE_N,
  .CODE_READY, .DAC_CODE, .DAC_CODE_VALID, .LOAD_TRANSPARENT, .CODE_STROBE);

// *** verif/sdl_host_model.sv ***
// host model driving the serial link
`timescale 1ns/1ps
module sdl_host_model (output logic lclk, output logic sd, output logic strobe_n);
  // idle: link clock stands low, strobe high
  initial begin
    lclk = 1'b0;
    sd = 1'b0;
    strobe_n = 1'b1;
  end
  task automatic tick();
    #62.5 lclk = 1'b1;
    #62.5 lclk = 1'b0;
  endtask : tick
  // msb first, strobe only after the whole word; n stray clocks while low
  task automatic xfer(input logic [15:0] w, input int n);
    for (int i = 15; i >= 0; i--) begin
      sd = w[i];
      tick();
    end
    sd = ~sd; // released line shows no stale bit
    strobe_n = 1'b0;
    repeat (n) tick();
    #200 strobe_n = 1'b1;
  endtask : xfer
endmodule : sdl_host_model

// *** verif/test_sdl_load_logic.sv ***
// self-checking bench for the serial load logic
`timescale 1ns/1ps
module test_sdl_load_logic;
  logic CORE_CLK = 1'b0, RST = 1'b1, rdy = 1'b1, lclk, sd, stb_n, vld, tr, cs;
  logic [11:0] code;
  int fail_count = 0, n_tests = 0, cyc = 0;
  sdl_host_model sdl_host_model_i (.lclk, .sd, .strobe_n(stb_n));
  sdl_load_logic sdl_load_logic_i (.CORE_CLK, .RST, .LINK_CLK(lclk), .SERIAL_DATA_IN(sd),
    .LOAD_STROBE_N(stb_n), .DAC_CODE(code), .DAC_CODE_VALID(vld), .LOAD_TRANSPARENT(tr),
    .CODE_READY(rdy), .CODE_STROBE(cs));
  // core clock and a hang guard well above the run length
  initial forever #5 CORE_CLK = ~CORE_CLK;
  always @(posedge CORE_CLK) begin
    if (++cyc == 5000) begin
      fail_count++;
      finish_test();
    end
  end
  task automatic cmp(input logic [11:0] exp, input logic [11:0] got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD code expected %h seen %h", exp, got);
    end
  endtask : cmp
  task automatic cmp_bit(input string nm, input logic exp, input logic got);
    n_tests++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD %s expected %b seen %b", nm, exp, got);
    end
  endtask : cmp_bit
  task automatic finish_test();
    $display("checks %0d fails %0d", n_tests, fail_count);
    if (fail_count == 0 && n_tests > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : finish_test
  // junk lead nibble must fall out; stray clocks while low must not shift
  task automatic t_word(input logic [15:0] w, input int n);
    sdl_host_model_i.xfer(w, n);
    #300;
    @(negedge CORE_CLK);
    cmp(w[11:0], code);
    cmp_bit("valid", 1'b1, vld);
    cmp_bit("transparent", 1'b0, tr);
    cmp_bit("strobe", 1'b0, cs);
  endtask : t_word
  // ladder side stalled: old code holds, new one follows once ready
  task automatic t_stall();
    @(negedge CORE_CLK) rdy = 1'b0;
    sdl_host_model_i.xfer(16'hB456, 0);
    #300;
    @(negedge CORE_CLK);
    cmp(12'h800, code);
    rdy = 1'b1;
    #300;
    @(negedge CORE_CLK);
    cmp(12'h456, code);
  endtask : t_stall
  // reset for six cycles, then the scenarios
  initial begin
    repeat (6) @(negedge CORE_CLK);
    RST = 1'b0;
    @(negedge CORE_CLK);
    cmp_bit("valid", 1'b0, vld);
    cmp_bit("transparent", 1'b0, tr);
    t_word(16'hA5C3, 0);
    t_word(16'h0FFF, 3);
    t_word(16'hF000, 0);
    t_word(16'h5800, 0);
    t_stall();
    finish_test();
  end
endmodule : test_sdl_load_logic
